// ===== logic/ssr_map.svh
// ssr_map.svh: offsets, field positions, reset values of the status readback
// assumes: included by the status readback module only
`ifndef SSR_MAP_SVH
`define SSR_MAP_SVH

// message layout: toggle bit, address field, data nibble
`define SSR_TOGGLE_POS 7
`define SSR_ADDR_MSB 6
`define SSR_ADDR_LSB 4
`define SSR_DATA_MSB 3

// register addresses, also the readback selector codes
`define SSR_ADDR_STATUS 3'h0
`define SSR_ADDR_OUTCTL 3'h1
`define SSR_ADDR_OCLEVEL 3'h2
`define SSR_ADDR_DETTIME 3'h3
`define SSR_ADDR_DIRIN 3'h4
`define SSR_ADDR_DLY_WD 3'h5
`define SSR_ADDR_NOP_UOV 3'h6
`define SSR_ADDR_TEST 3'h7

// field positions
`define SSR_OCR_ON0 0
`define SSR_OCR_ON1 2
`define SSR_DIC_DIS 1
`define SSR_CDT_OLDIS 3
`define SSR_UOV_UVDIS 1
`define SSR_UOV_OVDIS 0

// reset values
`define SSR_SEL_RESET 3'h7
`define SSR_CFG_RESET 4'h0
`define SSR_CS_IDLE 1'b1

`endif

// ===== logic/ssr_pkg.sv
// ssr_pkg: state types of the serial status readback
// assumes: ssr_map.svh on the include path
package ssr_pkg;

    typedef logic [2:0] ssr_sel_t;
    typedef logic [3:0] ssr_nib_t;

    // system clock domain state
    typedef struct packed {
        logic cs_d;
        ssr_sel_t sel;
        logic chan;
        ssr_nib_t outctl;
        logic [1:0][3:0] oc_level;
        logic [1:0][3:0] det_time;
        logic [1:0][3:0] dir_cfg;
        logic [2:0] sw_delay;
        logic [1:0] wd_period;
        logic [1:0] uov_cfg;
        logic [1:0] och_flag;
        logic [1:0] ocl_flag;
        logic summary;
        logic [1:0] din_d;
        logic [7:0] status;
        logic fs_act;
    } ssr_core_s;

    // serial clock domain receive state
    typedef struct packed {
        logic [7:0] shift;
        logic [2:0] low3;
        logic got8;
    } ssr_rx_s;

endpackage : ssr_pkg

// ===== logic/ssr_status_readback.sv
// ssr_status_readback: serial status byte builder and shifter of a dual
// high-side switch, with the fault flags and stored readback configuration
// assumes: spi master shifts on falling sclk, samples on rising; protection
// and watchdog inputs come from logic on clk; pins arrive unsynchronised
`timescale 1ns/10ps
`include "ssr_map.svh"

module ssr_status_readback
    import ssr_pkg::*;
#(
    parameter int SYNC_DEPTH = 2,
    parameter logic NULL_OD3 = 1'b0
)
(
    // system clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // serial link
    input wire logic sclk,
    input wire logic cs_b,
    input wire logic si,
    output logic so_out,
    output logic so_oe,
    // device pins read back
    input wire logic direct_in0,
    input wire logic direct_in1,
    input wire logic failsafe_resistor_in,
    input wire logic wake_in,
    // open-drain fault status pin, active low
    output logic fault_status_b_out,
    output logic fault_status_b_oe,
    // protection conditions, per channel except under- and overvoltage
    input wire logic [1:0] overtemperature_flag,
    input wire logic [1:0] overcurrent_high_flag,
    input wire logic [1:0] overcurrent_low_flag,
    input wire logic [1:0] open_load_flag,
    input wire logic undervoltage_flag,
    input wire logic overvoltage_flag,
    // watchdog and fail-safe state
    input wire logic watchdog_expired,
    input wire logic failsafe_state_out0,
    input wire logic failsafe_state_out1
);

    if (SYNC_DEPTH < 2)
    begin : g_bad_depth
        $error("SYNC_DEPTH must be at least 2");
    end

    localparam int NSYNC = 5;
    localparam int CS_IDX = 4;

    logic [SYNC_DEPTH-1:0] sync_reg [NSYNC];
    logic [NSYNC-1:0] sync_in;
    logic cs_s;
    logic din0_s;
    logic din1_s;
    logic fsi_s;
    logic wake_s;

    ssr_core_s core_reg;
    ssr_core_s core_next;
    ssr_rx_s rx_reg;
    ssr_rx_s rx_next;
    logic in_frame_reg;
    logic tx_started_reg;
    logic so_reg;

    logic cs_rise;
    logic cs_fall;
    logic msg_valid;
    logic tog;
    ssr_sel_t addr;
    ssr_nib_t dat;
    logic [1:0] on_cmd;
    logic [1:0] din_s;
    logic [1:0] ol_m;
    logic uv_m;
    logic ov_m;
    logic any_fault;
    logic [6:0] low7;

    // pin synchronisers; only the last stage is read
    assign sync_in = {cs_b, direct_in1, direct_in0,
                      failsafe_resistor_in, wake_in};

    for (genvar i = 0; i < NSYNC; i++)
    begin : g_sync
        always_ff @(posedge clk or negedge rst_b)
        begin
            if (!rst_b)
            begin
                sync_reg[i] <= (i == CS_IDX) ? '1 : '0;
            end
            else
            begin
                sync_reg[i] <= {sync_reg[i][SYNC_DEPTH-2:0], sync_in[i]};
            end
        end
    end

    assign cs_s = sync_reg[4][SYNC_DEPTH-1];
    assign din1_s = sync_reg[3][SYNC_DEPTH-1];
    assign din0_s = sync_reg[2][SYNC_DEPTH-1];
    assign fsi_s = sync_reg[1][SYNC_DEPTH-1];
    assign wake_s = sync_reg[0][SYNC_DEPTH-1];
    assign din_s = {din1_s, din0_s};

    // link side: frame flag cleared by the frame's own select
    always_ff @(posedge sclk or posedge cs_b)
    begin
        if (cs_b)
        begin
            in_frame_reg <= 1'b0;
        end
        else
        begin
            in_frame_reg <= 1'b1;
        end
    end

    // receive on rising sclk; count kept modulo eight
    always_comb
    begin
        rx_next = rx_reg;
        rx_next.shift = {rx_reg.shift[6:0], si};
        if (!in_frame_reg)
        begin
            rx_next.low3 = 3'h1;
            rx_next.got8 = 1'b0;
        end
        else
        begin
            rx_next.low3 = rx_reg.low3 + 3'h1;
            rx_next.got8 = rx_reg.got8 | (rx_reg.low3 == 3'h7);
        end
    end

    always_ff @(posedge sclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rx_reg <= '0;
        end
        else
        begin
            rx_reg <= rx_next;
        end
    end

    always_ff @(negedge sclk or posedge cs_b)
    begin
        if (cs_b)
        begin
            tx_started_reg <= 1'b0;
        end
        else
        begin
            tx_started_reg <= 1'b1;
        end
    end

    // status word is frozen on clk while select is low, so it is stable here
    always_ff @(negedge sclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            so_reg <= 1'b0;
        end
        else if (rx_reg.got8)
        begin
            so_reg <= rx_reg.shift[7];
        end
        else
        begin
            so_reg <= core_reg.status[~rx_reg.low3];
        end
    end

    // first bit must be out before any sclk edge, hence the mux on the pin
    assign so_out = tx_started_reg ? so_reg : core_reg.status[7];
    assign so_oe = ~cs_b;
    assign fault_status_b_out = 1'b0;
    assign fault_status_b_oe = core_reg.fs_act;

    // frame end: receive state is quiet, sclk stands still while cs is high
    assign cs_rise = cs_s & ~core_reg.cs_d;
    assign cs_fall = ~cs_s & core_reg.cs_d;
    assign msg_valid = cs_rise & rx_reg.got8 & (rx_reg.low3 == 3'h0);
    assign tog = rx_reg.shift[`SSR_TOGGLE_POS];
    assign addr = rx_reg.shift[`SSR_ADDR_MSB:`SSR_ADDR_LSB];
    assign dat = rx_reg.shift[`SSR_DATA_MSB:0];

    always_comb
    begin
        core_next = core_reg;
        core_next.cs_d = cs_s;
        core_next.din_d = din_s;
        on_cmd = 2'b00;
        if (msg_valid)
        begin
            core_next.chan = tog;
            unique case (addr)
                `SSR_ADDR_STATUS:
                begin
                    core_next.sel = dat[2:0];
                end
                `SSR_ADDR_OUTCTL:
                begin
                    core_next.outctl = dat;
                    on_cmd[0] = dat[`SSR_OCR_ON0]
                        & ~core_reg.outctl[`SSR_OCR_ON0];
                    on_cmd[1] = dat[`SSR_OCR_ON1]
                        & ~core_reg.outctl[`SSR_OCR_ON1];
                end
                `SSR_ADDR_OCLEVEL:
                begin
                    core_next.oc_level[tog] = dat;
                end
                `SSR_ADDR_DETTIME:
                begin
                    core_next.det_time[tog] = dat;
                end
                `SSR_ADDR_DIRIN:
                begin
                    core_next.dir_cfg[tog] = dat;
                end
                `SSR_ADDR_DLY_WD:
                begin
                    if (tog)
                    begin
                        core_next.wd_period = dat[1:0];
                    end
                    else
                    begin
                        core_next.sw_delay = dat[2:0];
                    end
                end
                `SSR_ADDR_NOP_UOV:
                begin
                    if (tog)
                    begin
                        core_next.uov_cfg = dat[1:0];
                    end
                end
                `SSR_ADDR_TEST:
                begin
                end
            endcase
        end

        // direct input switch-on counts only while direct control is enabled
        for (int c = 0; c < 2; c++)
        begin
            if (din_s[c] & ~core_reg.din_d[c]
                & ~core_reg.dir_cfg[c][`SSR_DIC_DIS])
            begin
                on_cmd[c] = 1'b1;
            end
            // set wins over the switch-on clear
            core_next.och_flag[c] = overcurrent_high_flag[c]
                | (core_reg.och_flag[c] & ~on_cmd[c]);
            core_next.ocl_flag[c] = overcurrent_low_flag[c]
                | (core_reg.ocl_flag[c] & ~on_cmd[c]);
            ol_m[c] = open_load_flag[c]
                & ~core_reg.det_time[c][`SSR_CDT_OLDIS];
        end

        // undervoltage reported non-latched
        uv_m = undervoltage_flag & ~core_reg.uov_cfg[`SSR_UOV_UVDIS];
        ov_m = overvoltage_flag & ~core_reg.uov_cfg[`SSR_UOV_OVDIS];
        any_fault = (|overtemperature_flag) | (|core_next.och_flag)
            | (|core_next.ocl_flag) | (|ol_m) | uv_m | ov_m;
        core_next.fs_act = any_fault;
        // read happens when the fault byte is loaded at select fall
        core_next.summary = any_fault | (core_reg.summary
            & ~(cs_fall & (core_reg.sel == `SSR_ADDR_STATUS)));

        low7 = {core_reg.sel, 4'h0};
        unique case (core_reg.sel)
            `SSR_ADDR_STATUS:
            begin
                low7 = {overtemperature_flag[core_reg.chan],
                        core_reg.och_flag[core_reg.chan],
                        core_reg.ocl_flag[core_reg.chan],
                        ol_m[core_reg.chan], uv_m, ov_m,
                        core_reg.summary};
            end
            `SSR_ADDR_OUTCTL:
            begin
                low7[3:0] = core_reg.outctl;
            end
            `SSR_ADDR_OCLEVEL:
            begin
                low7[3:0] = core_reg.oc_level[core_reg.chan];
            end
            `SSR_ADDR_DETTIME:
            begin
                low7[3:0] = core_reg.det_time[core_reg.chan];
            end
            `SSR_ADDR_DIRIN:
            begin
                low7[3:0] = core_reg.dir_cfg[core_reg.chan];
            end
            `SSR_ADDR_DLY_WD:
            begin
                if (core_reg.chan)
                begin
                    low7[3:0] = {failsafe_state_out1, watchdog_expired,
                                 core_reg.wd_period};
                end
                else
                begin
                    low7[3:0] = {failsafe_state_out0,
                                 core_reg.sw_delay};
                end
            end
            `SSR_ADDR_NOP_UOV:
            begin
                if (core_reg.chan)
                begin
                    low7[3:0] = {2'b00, core_reg.uov_cfg};
                end
                else
                begin
                    low7[3:0] = {din1_s, din0_s, fsi_s, wake_s};
                end
            end
            `SSR_ADDR_TEST:
            begin
                low7[3:0] = {NULL_OD3, 3'h0};
            end
        endcase

        // byte only refreshes between frames so the shifter sees it still
        if (cs_s)
        begin
            core_next.status = {core_reg.chan, low7};
        end
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            core_reg <= '0;
            core_reg.cs_d <= `SSR_CS_IDLE;
            core_reg.sel <= `SSR_SEL_RESET;
            core_reg.status <= {1'b0, `SSR_SEL_RESET, `SSR_CFG_RESET};
        end
        else
        begin
            core_reg <= core_next;
        end
    end

endmodule : ssr_status_readback

// ===== verif/ssr_status_readback_assertions.sv
// ssr_status_readback_assertions: port checks of the status readback
// assumes: bound to every ssr_status_readback instance
`timescale 1ns/10ps

module ssr_status_readback_assertions (
    // clocks and reset
    input wire logic clk,
    input wire logic rst_b,
    input wire logic sclk,
    // serial link
    input wire logic cs_b,
    input wire logic si,
    input wire logic so_out,
    input wire logic so_oe,
    // fault pin and its causes
    input wire logic fault_status_b_out,
    input wire logic fault_status_b_oe,
    input wire logic [1:0] overtemperature_flag,
    input wire logic [1:0] overcurrent_high_flag
);
    logic [3:0] bit_cnt;
    logic [7:0] si_hist;

    // cleared by select high, so every frame counts from its first bit
    always_ff @(posedge sclk or posedge cs_b)
    begin
        if (cs_b)
        begin
            bit_cnt <= 4'h0;
            si_hist <= 8'h00;
        end
        else
        begin
            if (bit_cnt != 4'hf)
                bit_cnt <= bit_cnt + 4'h1;
            si_hist <= {si_hist[6:0], si};
        end
    end

    a_oe_idle: assert property (@(posedge clk) disable iff (!rst_b)
        cs_b |-> !so_oe) else $error("serial out driven while idle");
    a_oe_frame: assert property (@(posedge clk) disable iff (!rst_b)
        !cs_b |-> so_oe) else $error("serial out not driven in frame");
    a_fs_drain: assert property (@(posedge clk) disable iff (!rst_b)
        fault_status_b_out == 1'b0) else $error("fault pin data not low");
    a_fs_heat: assert property (@(posedge clk) disable iff (!rst_b)
        |overtemperature_flag |=> fault_status_b_oe)
        else $error("fault pin idle on overtemperature");
    a_fs_och: assert property (@(posedge clk) disable iff (!rst_b)
        $rose(|overcurrent_high_flag) |=> fault_status_b_oe)
        else $error("fault pin idle on overcurrent");
    a_och_held: assert property (@(posedge clk) disable iff (!rst_b)
        $fell(overcurrent_high_flag[1]) && cs_b |=> fault_status_b_oe [*3])
        else $error("overcurrent fault not held");
    a_fs_reset: assert property (@(posedge clk) disable iff (!rst_b)
        $rose(rst_b) |-> !fault_status_b_oe)
        else $error("fault pin active out of reset");
    // only holds once the status byte has gone, hence the count
    a_so_forward: assert property (@(posedge sclk)
        disable iff (!rst_b || cs_b)
        bit_cnt >= 4'h8 |-> so_out == si_hist[7])
        else $error("serial in not forwarded");

    c_frame: cover property (@(posedge clk) $fell(cs_b));
    c_daisy: cover property (@(posedge sclk) bit_cnt == 4'hf);
    c_och: cover property (@(posedge clk) $rose(|overcurrent_high_flag));
endmodule : ssr_status_readback_assertions

bind ssr_status_readback ssr_status_readback_assertions
    ssr_status_readback_assertions_i (
    .clk(clk),
    .rst_b(rst_b),
    .sclk(sclk),
    .cs_b(cs_b),
    .si(si),
    .so_out(so_out),
    .so_oe(so_oe),
    .fault_status_b_out(fault_status_b_out),
    .fault_status_b_oe(fault_status_b_oe),
    .overtemperature_flag(overtemperature_flag),
    .overcurrent_high_flag(overcurrent_high_flag)
);

// ===== verif/ssr_spi_master.sv
// ssr_spi_master: behavioural spi master, mode 0, on its own link clock
// assumes: a single device on the chain; caller spaces the frames
`timescale 1ns/10ps

module ssr_spi_master (
    // serial link
    output logic sclk,
    output logic cs_b,
    output logic si,
    input wire logic so_out
);
    initial
    begin
        sclk = 1'b0;
        cs_b = 1'b1;
        si = 1'b0;
    end

    // link clock runs only inside a frame, 15 ns period
    task automatic xfer(input logic [15:0] tx, input int n,
        output logic [15:0] rx);
        rx = 16'h0000;
        cs_b = 1'b0;
        for (int i = n - 1; i >= 0; i--)
        begin
            si = tx[i];
            #7.5 sclk = 1'b1;
            rx = {rx[14:0], so_out};
            #7.5 sclk = 1'b0;
        end
        #7.5 cs_b = 1'b1;
        // released line shows the inverse, never a stale bit
        si = ~si;
    endtask : xfer
endmodule : ssr_spi_master

// ===== verif/ssr_status_readback_tb.sv
// ssr_status_readback_tb: self-checking bench of the status readback
// assumes: design, checker and master model compiled before it
`timescale 1ns/10ps

module ssr_status_readback_tb;
    typedef struct packed {
        logic [7:0] sel;
        logic [7:0] cfg;
        logic [7:0] exp;
    } ssr_row_s;

    ssr_row_s rows [9] = '{
        '{8'h01, 8'h1b, 8'h1b},
        '{8'h82, 8'ha5, 8'ha5},
        '{8'h03, 8'h3d, 8'h3d},
        '{8'h84, 8'hca, 8'hca},
        '{8'h05, 8'h56, 8'h5e},
        '{8'h85, 8'hd2, 8'hde},
        '{8'h06, 8'h60, 8'h6a},
        '{8'h86, 8'he3, 8'he3},
        '{8'h07, 8'h60, 8'h70}
    };

    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic sclk;
    logic cs_b;
    logic si;
    logic so_out;
    logic so_oe;
    logic fs_out;
    logic fs_oe;
    logic din0 = 1'b0;
    logic din1 = 1'b1;
    logic fsr = 1'b1;
    logic wake = 1'b0;
    logic [1:0] ot = 2'h0;
    logic [1:0] och = 2'h0;
    logic [1:0] ocl = 2'h0;
    logic [1:0] ol = 2'h0;
    logic uv = 1'b0;
    logic ov = 1'b0;
    logic wde = 1'b1;
    logic fs0 = 1'b1;
    logic fs1 = 1'b1;
    logic [15:0] rx;
    int fail_count = 0;
    int cmp_count = 0;
    int cyc = 0;

    ssr_status_readback ssr_status_readback_i (
        .clk(clk),
        .rst_b(rst_b),
        .sclk(sclk),
        .cs_b(cs_b),
        .si(si),
        .so_out(so_out),
        .so_oe(so_oe),
        .direct_in0(din0),
        .direct_in1(din1),
        .failsafe_resistor_in(fsr),
        .wake_in(wake),
        .fault_status_b_out(fs_out),
        .fault_status_b_oe(fs_oe),
        .overtemperature_flag(ot),
        .overcurrent_high_flag(och),
        .overcurrent_low_flag(ocl),
        .open_load_flag(ol),
        .undervoltage_flag(uv),
        .overvoltage_flag(ov),
        .watchdog_expired(wde),
        .failsafe_state_out0(fs0),
        .failsafe_state_out1(fs1)
    );

    ssr_spi_master ssr_spi_master_i (
        .sclk(sclk),
        .cs_b(cs_b),
        .si(si),
        .so_out(so_out)
    );

    always #25 clk = ~clk;

    task automatic complete_run();
        $display("compares %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : complete_run

    always @(posedge clk)
    begin
        cyc = cyc + 1;
        if (cyc == 6000)
        begin
            fail_count++;
            complete_run();
        end
    end

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            fail_count++;
            $display("Error %0t: byte %h, wanted %h", $time, got, exp);
        end
    endtask : chk8

    task automatic chk1(input logic got, input logic exp);
        cmp_count++;
        if (got !== exp)
        begin
            fail_count++;
            $display("Error %0t: fault pin %b, wanted %b", $time, got, exp);
        end
    endtask : chk1

    // the gap covers select synchronising and the status refresh
    task automatic frame(input logic [15:0] tx, input int n);
        ssr_spi_master_i.xfer(tx, n, rx);
        repeat (6) @(negedge clk);
    endtask : frame

    task automatic reset_chk();
        rst_b = 1'b0;
        repeat (4) @(negedge clk);
        rst_b = 1'b1;
        repeat (4) @(negedge clk);
        frame(16'h0007, 8);
        chk8(rx[7:0], 8'h70);
        chk1(fs_oe, 1'b0);
        $display("reset test done");
    endtask : reset_chk

    initial
    begin
        reset_chk();
        for (int r = 0; r < 9; r++)
        begin
            frame({8'h00, rows[r].sel}, 8);
            frame({8'h00, rows[r].cfg}, 8);
            frame({8'h00, rows[r].cfg}, 8);
            chk8(rx[7:0], rows[r].exp);
            $display("row %0d done", r);
        end
        fs0 = 1'b0;
        fs1 = 1'b0;
        wde = 1'b0;
        och[1] = 1'b1;
        ocl[1] = 1'b1;
        uv = 1'b1;
        ov = 1'b1;
        repeat (3) @(negedge clk);
        och[1] = 1'b0;
        ocl[1] = 1'b0;
        ot[1] = 1'b1;
        ol[1] = 1'b1;
        repeat (4) @(negedge clk);
        frame(16'h0080, 8);
        frame(16'h0080, 8);
        chk8(rx[7:0], 8'hf9);
        chk1(fs_oe, 1'b1);
        ot[1] = 1'b0;
        ol[1] = 1'b0;
        uv = 1'b0;
        ov = 1'b0;
        repeat (2) @(negedge clk);
        chk1(fs_oe, 1'b1);
        frame(16'h0014, 8);
        chk1(fs_oe, 1'b0);
        frame(16'h0080, 8);
        frame(16'h0080, 8);
        chk8(rx[7:0], 8'h80);
        $display("fault test done");
        frame(16'ha580, 16);
        chk8(rx[15:8], 8'h80);
        chk8(rx[7:0], 8'ha5);
        $display("chain test done");
        frame(16'h0001, 8);
        frame(16'h0002, 7);
        frame(16'h0001, 8);
        chk8(rx[7:0], 8'h14);
        $display("length test done");
        reset_chk();
        complete_run();
    end
endmodule : ssr_status_readback_tb
